// file: logic/dpllrs_pkg.sv
`default_nettype none
package dpllrs_pkg;
  localparam int NREF = 7;
  localparam int RW = 3;
  localparam int PW = 4;
  localparam int GW = 3;
  localparam int FW = 32;
  localparam int HW = 6;
  localparam logic [RW-1:0] REF_LAST = 3'h6;
  localparam logic [3:0] MODE_AUTO = 4'h0;
  localparam logic [3:0] MODE_MANUAL = 4'h1;
  localparam logic [3:0] MODE_PIN = 4'h2;
  localparam logic [3:0] MODE_SLAVE = 4'h3;
  localparam logic [3:0] MODE_PIN_SLAVE = 4'h4;
  localparam int SEC_NS = 1000000000;
  localparam int CLK_NS = 25;
  localparam int SEC_CYCLES = SEC_NS / CLK_NS;
  localparam logic [HW-1:0] HIST_MAX_S = 6'h3f;
  localparam int BW_N = 17;
  localparam int BWW = 5;
  // nominal bandwidths in units of 0.1 mHz
  localparam logic [31:0] BW_TABLE [BW_N] = '{
    32'h0000039e, 32'h00000adc, 32'h000015b8, 32'h00002b5c, 32'h000056b8,
    32'h0000add4, 32'h00015b38, 32'h0002b750, 32'h00056ea0,
    32'h000add40, 32'h000e6780, 32'h0015aba0, 32'h002b7d10, 32'h0032d0d0,
    32'h00572030, 32'h06cb8080, 32'h0736b1c0};
  typedef enum logic [5:0] {
    S_FREE = 6'h01,
    S_ACQ = 6'h02,
    S_LOCKED = 6'h04,
    S_HOLD = 6'h08,
    S_LOCK_RECOVERY = 6'h10,
    S_HITLESS = 6'h20
  } dpllrs_state_t;
endpackage
`default_nettype wire

// file: logic/dpllrs_ref_pick.sv
`default_nettype none
module dpllrs_ref_pick
  import dpllrs_pkg::*;
(
  // candidates
  input wire logic [NREF-1:0] qual,
  input wire logic [NREF*PW-1:0] prio,
  // choice
  output logic found,
  output logic [RW-1:0] idx
);
  logic [PW-1:0] prio_a [NREF];
  logic [PW-1:0] best;

  genvar g;
  generate
    for (g = 0; g < NREF; g++) begin : g_unpack
      assign prio_a[g] = prio[g*PW +: PW];
    end
  endgenerate

  // lower code is higher priority, lower index breaks ties
  always_comb begin
    found = 1'b0;
    idx = '0;
    best = '1;
    for (int i = 0; i < NREF; i++) begin
      if (qual[i] && (!found || prio_a[i] < best)) begin
        found = 1'b1;
        idx = RW'(i);
        best = prio_a[i];
      end
    end
  end
endmodule
`default_nettype wire

// file: logic/dpllrs_hold_hist.sv
`default_nettype none
module dpllrs_hold_hist
  import dpllrs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic sec_tick,
  input wire logic capture_en,
  input wire logic [HW-1:0] interval,
  input wire logic signed [FW-1:0] freq_in,
  // history
  output logic signed [FW-1:0] older
);
  typedef struct packed {
    logic [HW-1:0] cnt;
    logic signed [FW-1:0] newer;
    logic signed [FW-1:0] older;
  } dpllrs_hist_t;

  dpllrs_hist_t st_ff;
  dpllrs_hist_t nxt_st;
  logic upd;

  // interval 0 stores on every one-second tick
  assign upd = capture_en && sec_tick && st_ff.cnt >= interval;

  always_comb begin
    nxt_st = st_ff;
    if (!capture_en) begin
      nxt_st.cnt = '0;
    end else if (upd) begin
      nxt_st.cnt = '0;
      nxt_st.older = st_ff.newer;
      nxt_st.newer = freq_in;
    end else if (sec_tick && st_ff.cnt != HIST_MAX_S) begin
      nxt_st.cnt = st_ff.cnt + 6'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign older = st_ff.older;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_hist_shift: assert property (upd |=> st_ff.older == $past(st_ff.newer) && st_ff.newer == $past(freq_in))
    else $error("history words did not shift");
  a_hist_interval: assert property (!(capture_en && sec_tick && st_ff.cnt >= interval)
      |=> $stable(st_ff.older) && $stable(st_ff.newer))
    else $error("history stored before interval");
endmodule
`default_nettype wire

// file: logic/dpllrs_channel.sv
`default_nettype none
module dpllrs_channel
  import dpllrs_pkg::*;
#(
  parameter int SEC_CYC = SEC_CYCLES
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // reference monitors and selection config
  input wire logic [NREF-1:0] REF_VALID,
  input wire logic [NREF-1:0] REF_ENABLE,
  input wire logic [NREF*PW-1:0] REFERENCE_PRIORITY_FIELD,
  input wire logic [NREF*GW-1:0] REF_GROUP_FIELD,
  input wire logic [3:0] REFERENCE_MODE_CODE,
  input wire logic [RW-1:0] MANUAL_REF_SEL,
  input wire logic [RW-1:0] SEL_PIN,
  input wire logic [RW-1:0] SLAVE_REF_SEL,
  input wire logic SLAVE_PIN,
  input wire logic REVERTIVE_EN,
  input wire logic HITLESS_SWITCHING_EN,
  // holdover config
  input wire logic FORCE_HOLDOVER,
  input wire logic MANUAL_HOLDOVER,
  input wire logic signed [FW-1:0] MANUAL_HOLDOVER_VALUE,
  input wire logic ADV_HOLDOVER_EN,
  input wire logic [HW-1:0] HISTORY_INTERVAL,
  // limits and bandwidth
  input wire logic PHASE_SLOPE_LIMIT_EN,
  input wire logic [15:0] PHASE_SLOPE_LIMIT,
  input wire logic [FW-2:0] FREQ_OFFSET_LIMIT,
  input wire logic [31:0] BW_REQUEST,
  // loop feedback
  input wire logic LOOP_LOCKED,
  input wire logic signed [FW-1:0] LOOP_FREQ_OFFSET,
  input wire logic signed [FW-1:0] PHASE_MEAS,
  input wire logic PHASE_MEAS_VALID,
  // status
  output logic [5:0] STATE_REPORT,
  output logic [RW-1:0] SELECTED_REF,
  output logic HOLDOVER_ACTIVE,
  output logic [3:0] ACTIVE_MODE,
  // loop control
  output logic INTEGRATOR_LOAD,
  output logic signed [FW-1:0] INTEGRATOR_VALUE,
  output logic signed [FW-1:0] FREQ_STEER,
  output logic signed [FW-1:0] PHASE_COMP,
  output logic [BWW-1:0] BW_INDEX
);
  typedef struct packed {
    dpllrs_state_t state;
    dpllrs_state_t rep;
    logic hold_act;
    logic [RW-1:0] sel;
    logic have_ref;
    logic [3:0] mode;
    logic signed [FW-1:0] hold_val;
    logic signed [FW-1:0] last_off;
    logic int_load;
    logic signed [FW-1:0] int_val;
    logic signed [FW-1:0] steer;
    logic signed [FW-1:0] ph_tgt;
    logic signed [FW-1:0] ph_out;
    logic [BWW-1:0] bw_idx;
    logic [31:0] sec_cnt;
    logic tick;
  } dpllrs_chan_t;

  localparam dpllrs_chan_t RST_ST = '{state: S_FREE, rep: S_FREE, default: '0};

  dpllrs_chan_t st_ff;
  dpllrs_chan_t nxt_st;
  logic [3:0] mode_cur;
  logic [NREF-1:0] qual;
  logic pk_found;
  logic [RW-1:0] pk_idx;
  logic [RW-1:0] tgt;
  logic tgt_ok;
  logic use_auto;
  logic forced;
  logic sw;
  logic signed [FW-1:0] hist_old;
  logic signed [FW-1:0] lim;
  logic signed [FW-1:0] step;

  assign qual = REF_ENABLE & REF_VALID;
  assign forced = FORCE_HOLDOVER | MANUAL_HOLDOVER;
  assign lim = {1'b0, FREQ_OFFSET_LIMIT};
  assign step = FW'({16'h0000, PHASE_SLOPE_LIMIT}) + 32'sh1;

  dpllrs_ref_pick u_pick (
    .qual(qual),
    .prio(REFERENCE_PRIORITY_FIELD),
    .found(pk_found),
    .idx(pk_idx)
  );

  dpllrs_hold_hist u_hist (
    .clk(MCLK),
    .rst_n(RESET_N),
    .sec_tick(st_ff.tick),
    .capture_en(st_ff.state == S_LOCKED && ADV_HOLDOVER_EN),
    .interval(HISTORY_INTERVAL),
    .freq_in(LOOP_FREQ_OFFSET),
    .older(hist_old)
  );

  // reference target for this cycle
  always_comb begin
    mode_cur = (REFERENCE_MODE_CODE <= MODE_PIN_SLAVE) ? REFERENCE_MODE_CODE : st_ff.mode;
    use_auto = 1'b0;
    tgt = st_ff.sel;
    case (mode_cur)
      MODE_MANUAL: tgt = MANUAL_REF_SEL;
      MODE_PIN: tgt = SEL_PIN;
      MODE_SLAVE: tgt = SLAVE_REF_SEL;
      MODE_PIN_SLAVE: begin
        if (SLAVE_PIN) begin
          tgt = SLAVE_REF_SEL;
        end else begin
          use_auto = 1'b1;
        end
      end
      default: use_auto = 1'b1;
    endcase
    // fixed choices only check the monitor, never fall back elsewhere
    tgt_ok = tgt <= REF_LAST && REF_VALID[tgt];
    if (use_auto) begin
      if (st_ff.have_ref && qual[st_ff.sel]) begin
        tgt = st_ff.sel;
        tgt_ok = 1'b1;
        if (REVERTIVE_EN && pk_found
            && REFERENCE_PRIORITY_FIELD[pk_idx*PW +: PW] < REFERENCE_PRIORITY_FIELD[st_ff.sel*PW +: PW]
            && !(REF_GROUP_FIELD[pk_idx*GW +: GW] != '0
                 && REF_GROUP_FIELD[pk_idx*GW +: GW] == REF_GROUP_FIELD[st_ff.sel*GW +: GW])) begin
          tgt = pk_idx;
        end
      end else begin
        tgt = pk_idx;
        tgt_ok = pk_found;
      end
    end
    sw = tgt != st_ff.sel || !st_ff.have_ref;
  end

  always_comb begin
    logic go_hold;
    logic signed [FW-1:0] raw;
    logic signed [FW-1:0] diff;
    go_hold = 1'b0;
    raw = '0;
    diff = '0;
    nxt_st = st_ff;
    nxt_st.int_load = 1'b0;
    nxt_st.mode = mode_cur;
    case (st_ff.state)
      S_FREE: begin
        if (tgt_ok) begin
          nxt_st.state = S_ACQ;
          nxt_st.sel = tgt;
          nxt_st.have_ref = 1'b1;
        end
      end
      S_ACQ, S_LOCK_RECOVERY: begin
        if (!tgt_ok) begin
          if (st_ff.state == S_ACQ) begin
            nxt_st.state = S_FREE;
          end else begin
            go_hold = 1'b1;
          end
        end else if (sw) begin
          nxt_st.sel = tgt;
        end else if (LOOP_LOCKED) begin
          nxt_st.state = S_LOCKED;
        end
      end
      S_LOCKED: begin
        if (!tgt_ok) begin
          go_hold = 1'b1;
        end else if (sw) begin
          nxt_st.sel = tgt;
          nxt_st.state = HITLESS_SWITCHING_EN ? S_HITLESS : S_LOCK_RECOVERY;
        end
      end
      S_HOLD: begin
        if (!forced && tgt_ok) begin
          nxt_st.sel = tgt;
          nxt_st.have_ref = 1'b1;
          nxt_st.state = HITLESS_SWITCHING_EN ? S_HITLESS : S_LOCK_RECOVERY;
        end
      end
      S_HITLESS: begin
        if (!tgt_ok) begin
          go_hold = 1'b1;
        end else if (PHASE_MEAS_VALID) begin
          // measured offset of new input is cancelled at the output
          nxt_st.ph_tgt = st_ff.ph_tgt - PHASE_MEAS;
          nxt_st.state = S_LOCK_RECOVERY;
        end
      end
      default: nxt_st.state = S_FREE;
    endcase
    if (forced && st_ff.state != S_HOLD) begin
      go_hold = 1'b1;
    end
    if (go_hold) begin
      nxt_st.state = S_HOLD;
      if (MANUAL_HOLDOVER) begin
        nxt_st.hold_val = MANUAL_HOLDOVER_VALUE;
      end else if (ADV_HOLDOVER_EN) begin
        nxt_st.hold_val = hist_old;
        nxt_st.int_load = 1'b1;
        nxt_st.int_val = hist_old;
      end else begin
        nxt_st.hold_val = st_ff.last_off;
      end
    end
    if (st_ff.state == S_HOLD && MANUAL_HOLDOVER) begin
      nxt_st.hold_val = MANUAL_HOLDOVER_VALUE;
    end
    if (st_ff.state == S_ACQ || st_ff.state == S_LOCKED || st_ff.state == S_LOCK_RECOVERY) begin
      nxt_st.last_off = LOOP_FREQ_OFFSET;
    end
    // internal holdover is reported as lock recovery
    nxt_st.rep = (nxt_st.state == S_HITLESS) ? S_LOCK_RECOVERY : nxt_st.state;
    nxt_st.hold_act = nxt_st.state == S_HOLD;
    case (st_ff.state)
      S_FREE: raw = '0;
      S_HOLD: raw = st_ff.hold_val;
      S_HITLESS: raw = st_ff.last_off;
      default: raw = LOOP_FREQ_OFFSET;
    endcase
    if (raw > lim) begin
      raw = lim;
    end else if (raw < -lim) begin
      raw = -lim;
    end
    nxt_st.steer = raw;
    // one-second timebase
    nxt_st.tick = 1'b0;
    if (st_ff.sec_cnt >= 32'(SEC_CYC - 1)) begin
      nxt_st.sec_cnt = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.sec_cnt = st_ff.sec_cnt + 32'h1;
    end
    diff = st_ff.ph_tgt - st_ff.ph_out;
    if (!PHASE_SLOPE_LIMIT_EN || (diff <= step && diff >= -step)) begin
      nxt_st.ph_out = st_ff.ph_tgt;
    end else if (st_ff.tick) begin
      nxt_st.ph_out = (diff > 0) ? st_ff.ph_out + step : st_ff.ph_out - step;
    end
    nxt_st.bw_idx = '0;
    for (int i = 0; i < BW_N; i++) begin
      if (BW_TABLE[i] <= BW_REQUEST) begin
        nxt_st.bw_idx = BWW'(i);
      end
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_ff <= RST_ST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign STATE_REPORT = st_ff.rep;
  assign SELECTED_REF = st_ff.sel;
  assign HOLDOVER_ACTIVE = st_ff.hold_act;
  assign ACTIVE_MODE = st_ff.mode;
  assign INTEGRATOR_LOAD = st_ff.int_load;
  assign INTEGRATOR_VALUE = st_ff.int_val;
  assign FREQ_STEER = st_ff.steer;
  assign PHASE_COMP = st_ff.ph_out;
  assign BW_INDEX = st_ff.bw_idx;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  a_lost_all_hold: assert property ((st_ff.state == S_LOCKED && !tgt_ok) |=> st_ff.state == S_HOLD)
    else $error("locked channel without reference left outside holdover");
  a_simple_hold_val: assert property ((st_ff.state == S_LOCKED && !tgt_ok && !forced && !ADV_HOLDOVER_EN)
      |=> st_ff.hold_val == $past(st_ff.last_off))
    else $error("simple holdover value wrong");
  a_adv_int_load: assert property ((st_ff.state == S_LOCKED && !tgt_ok && !forced && ADV_HOLDOVER_EN)
      |=> st_ff.int_load && st_ff.int_val == $past(hist_old) ##1 !st_ff.int_load)
    else $error("integrator not loaded once from history");
  a_forced_hold: assert property (FORCE_HOLDOVER [*2] |=> st_ff.state == S_HOLD && HOLDOVER_ACTIVE)
    else $error("forced holdover left");
  a_manual_hold: assert property (MANUAL_HOLDOVER |=> st_ff.state == S_HOLD
      && st_ff.hold_val == $past(MANUAL_HOLDOVER_VALUE))
    else $error("manual holdover value not applied");
  a_reserved_mode: assert property (REFERENCE_MODE_CODE > MODE_PIN_SLAVE |=> $stable(st_ff.mode))
    else $error("reserved mode code changed mode");
  a_non_revert: assert property ((st_ff.state == S_LOCKED && !REVERTIVE_EN && !forced && use_auto
      && qual[st_ff.sel]) |=> $stable(st_ff.sel))
    else $error("non-revertive switch away from valid reference");
  a_hold_exit: assert property ((st_ff.state == S_HOLD && !forced && tgt_ok && !HITLESS_SWITCHING_EN)
      |=> st_ff.state == S_LOCK_RECOVERY)
    else $error("holdover did not move to lock recovery");
  a_hitless_hidden: assert property (st_ff.state == S_HITLESS |-> STATE_REPORT == S_LOCK_RECOVERY
      && !HOLDOVER_ACTIVE && ($past(st_ff.state) != S_HITLESS || $past(st_ff.state, 2) != S_HITLESS
      || FREQ_STEER == $past(FREQ_STEER)))
    else $error("hitless holdover visible");
  a_steer_clamp: assert property (##1 FREQ_STEER <= $past(lim) && FREQ_STEER >= -$past(lim))
    else $error("frequency steer beyond limit");
  a_slope_cap: assert property (PHASE_SLOPE_LIMIT_EN [*2] |-> (PHASE_COMP - $past(PHASE_COMP) <= $past(step))
      && (PHASE_COMP - $past(PHASE_COMP) >= -$past(step)))
    else $error("phase moved faster than slope limit");
  a_bw_floor: assert property (##1 (BW_TABLE[BW_INDEX] <= $past(BW_REQUEST) || BW_INDEX == '0))
    else $error("bandwidth above request");
endmodule
`default_nettype wire

// file: verification/dpllrs_ref_partner.sv
`default_nettype none
module dpllrs_ref_partner (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // channel state and stimulus
  input wire logic [5:0] state,
  input wire logic signed [31:0] ofs,
  input wire logic signed [31:0] pm,
  // loop feedback
  output logic locked,
  output logic signed [31:0] freq,
  output logic signed [31:0] meas,
  output logic meas_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] age;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      age <= 4'h0;
    end else if (state == 6'h02 || state == 6'h10) begin
      age <= (age == 4'hf) ? age : age + 4'h1;
    end else begin
      age <= 4'h0;
    end
  end
  // lock detector needs a few cycles of acquisition
  assign locked = (age >= 4'h3) || (state == 6'h04);
  // one phase measurement early in recovery
  assign meas_valid = (age == 4'h2);
  // measurement word is stale outside its strobe
  assign meas = meas_valid ? pm : ~pm;
  assign freq = ofs;
endmodule
`default_nettype wire

// file: verification/dpllrs_channel_tb_top.sv
`default_nettype none
module dpllrs_channel_tb_top import dpllrs_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SEC = 20;
  localparam logic [31:0] OFS_A = 32'h3e8;
  localparam logic [31:0] OFS_B = 32'h7d0;
  localparam logic [31:0] MAN_VAL = 32'hffffffb3;
  localparam logic [31:0] PM = 32'h17d78400;
  localparam logic [3:0] md [6] = '{MODE_AUTO, MODE_MANUAL, MODE_MANUAL, MODE_PIN, MODE_SLAVE, MODE_PIN_SLAVE};
  localparam logic [NREF-1:0] vl [6] = '{7'h04, 7'h14, 7'h04, 7'h04, 7'h24, 7'h24};
  localparam logic [9:0] ex [6] = '{10'h022, 10'h024, 10'h244, 10'h022, 10'h025, 10'h025};
  typedef struct packed {logic [2:0] k; logic [31:0] v;} dpllrs_note_t;
  logic MCLK = 1'b0;
  logic RESET_N = 1'b0;
  logic [NREF-1:0] REF_VALID = 7'h00;
  logic [NREF-1:0] REF_ENABLE = 7'h06;
  logic [NREF*PW-1:0] REFERENCE_PRIORITY_FIELD = 28'hfff120f;
  logic [NREF*GW-1:0] REF_GROUP_FIELD = 21'h0;
  logic [3:0] REFERENCE_MODE_CODE = 4'h0;
  logic [RW-1:0] MANUAL_REF_SEL = 3'h0;
  logic [RW-1:0] SEL_PIN = 3'h0;
  logic [RW-1:0] SLAVE_REF_SEL = 3'h0;
  logic SLAVE_PIN = 1'b0;
  logic REVERTIVE_EN = 1'b0;
  logic HITLESS_SWITCHING_EN = 1'b0;
  logic FORCE_HOLDOVER = 1'b0;
  logic MANUAL_HOLDOVER = 1'b0;
  logic signed [FW-1:0] MANUAL_HOLDOVER_VALUE = MAN_VAL;
  logic ADV_HOLDOVER_EN = 1'b0;
  logic [HW-1:0] HISTORY_INTERVAL = 6'h00;
  logic PHASE_SLOPE_LIMIT_EN = 1'b0;
  logic [15:0] PHASE_SLOPE_LIMIT = 16'h0;
  logic [FW-2:0] FREQ_OFFSET_LIMIT = 31'h7fffffff;
  logic [31:0] BW_REQUEST = 32'h0;
  logic LOOP_LOCKED;
  logic signed [FW-1:0] LOOP_FREQ_OFFSET;
  logic signed [FW-1:0] PHASE_MEAS;
  logic PHASE_MEAS_VALID;
  logic [5:0] STATE_REPORT;
  logic [RW-1:0] SELECTED_REF;
  logic HOLDOVER_ACTIVE;
  logic [3:0] ACTIVE_MODE;
  logic INTEGRATOR_LOAD;
  logic signed [FW-1:0] INTEGRATOR_VALUE;
  logic signed [FW-1:0] FREQ_STEER;
  logic signed [FW-1:0] PHASE_COMP;
  logic [BWW-1:0] BW_INDEX;
  logic [31:0] ofs = OFS_A;
  logic chk = 1'b0;
  logic [31:0] r;
  int e;
  int n_mismatch = 0;
  int check_count = 0;
  dpllrs_note_t q [$];
  dpllrs_note_t cur;

  dpllrs_channel #(.SEC_CYC(SEC)) dpllrs_channel_inst (
    .MCLK, .RESET_N, .REF_VALID, .REF_ENABLE, .REFERENCE_PRIORITY_FIELD, .REF_GROUP_FIELD,
    .REFERENCE_MODE_CODE, .MANUAL_REF_SEL, .SEL_PIN, .SLAVE_REF_SEL, .SLAVE_PIN, .REVERTIVE_EN,
    .HITLESS_SWITCHING_EN, .FORCE_HOLDOVER, .MANUAL_HOLDOVER, .MANUAL_HOLDOVER_VALUE, .ADV_HOLDOVER_EN,
    .HISTORY_INTERVAL, .PHASE_SLOPE_LIMIT_EN, .PHASE_SLOPE_LIMIT, .FREQ_OFFSET_LIMIT, .BW_REQUEST,
    .LOOP_LOCKED, .LOOP_FREQ_OFFSET, .PHASE_MEAS, .PHASE_MEAS_VALID, .STATE_REPORT, .SELECTED_REF,
    .HOLDOVER_ACTIVE, .ACTIVE_MODE, .INTEGRATOR_LOAD, .INTEGRATOR_VALUE, .FREQ_STEER, .PHASE_COMP, .BW_INDEX);

  dpllrs_ref_partner dpllrs_ref_partner_inst (.clk(MCLK), .rst_n(RESET_N), .state(STATE_REPORT), .ofs(ofs),
    .pm(PM), .locked(LOOP_LOCKED), .freq(LOOP_FREQ_OFFSET), .meas(PHASE_MEAS), .meas_valid(PHASE_MEAS_VALID));

  always #12.5 MCLK = ~MCLK;

  task automatic final_report();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
  endtask

  task automatic note(input logic [2:0] k, input logic [31:0] v);
    q.push_back('{k, v});
    chk <= 1'b1;
    @(posedge MCLK);
    chk <= 1'b0;
    @(posedge MCLK);
  endtask

  task automatic cmp_stat(input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %0t status got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %0t word got %h exp %h", $time, got, exp);
    end
  endtask

  // oldest note against whatever result shows now
  always @(negedge MCLK) begin
    if (chk || INTEGRATOR_LOAD === 1'b1) begin
      if (q.size() == 0) begin
        n_mismatch++;
        $display("mismatch %0t result with nothing expected", $time);
      end else begin
        cur = q.pop_front();
        case (cur.k)
          3'h0: cmp_stat({HOLDOVER_ACTIVE, STATE_REPORT, SELECTED_REF}, cur.v[9:0]);
          3'h1: cmp_word(FREQ_STEER, cur.v);
          3'h2: cmp_stat({6'h0, ACTIVE_MODE}, cur.v[9:0]);
          3'h3: cmp_stat({5'h0, BW_INDEX}, cur.v[9:0]);
          3'h4: cmp_word(PHASE_COMP, cur.v);
          default: cmp_word(INTEGRATOR_VALUE, cur.v);
        endcase
      end
    end
  end

  initial begin
    repeat (5000) @(posedge MCLK);
    n_mismatch++;
    final_report();
  end

  initial begin
    void'($urandom(34));
    repeat (4) @(posedge MCLK);
    RESET_N <= 1'b1;
    tick(1);
    note(0, {1'b0, 6'h01, 3'h0});
    REF_VALID <= 7'h0c;
    tick(10);
    note(0, {1'b0, 6'h04, 3'h2});
    REF_VALID <= 7'h0e;
    tick(10);
    note(0, {1'b0, 6'h04, 3'h2});
    REF_GROUP_FIELD <= 21'h000048;
    REVERTIVE_EN <= 1'b1;
    tick(10);
    note(0, {1'b0, 6'h04, 3'h2});
    REF_GROUP_FIELD <= 21'h0;
    tick(12);
    note(0, {1'b0, 6'h04, 3'h1});
    REF_VALID <= 7'h00;
    tick(4);
    note(0, {1'b1, 6'h08, 3'h1});
    note(1, OFS_A);
    FREQ_OFFSET_LIMIT <= 31'h5;
    tick(3);
    note(1, 32'h5);
    FREQ_OFFSET_LIMIT <= 31'h7fffffff;
    REF_VALID <= 7'h04;
    tick(1);
    note(0, {1'b0, 6'h10, 3'h2});
    tick(10);
    FORCE_HOLDOVER <= 1'b1;
    tick(3);
    note(0, {1'b1, 6'h08, 3'h2});
    FORCE_HOLDOVER <= 1'b0;
    tick(12);
    MANUAL_HOLDOVER <= 1'b1;
    tick(4);
    note(1, MAN_VAL);
    MANUAL_HOLDOVER <= 1'b0;
    tick(12);
    HITLESS_SWITCHING_EN <= 1'b1;
    REF_VALID <= 7'h00;
    tick(4);
    REF_VALID <= 7'h04;
    tick(1);
    note(0, {1'b0, 6'h10, 3'h2});
    tick(6);
    note(4, -PM);
    HITLESS_SWITCHING_EN <= 1'b0;
    ADV_HOLDOVER_EN <= 1'b1;
    HISTORY_INTERVAL <= 6'h01;
    // stay locked for ten seconds, five history stores at interval 1, before trusting history
    tick(SEC * 10);
    ofs <= OFS_B;
    q.push_back('{3'h5, OFS_A});
    tick(1);
    REF_VALID <= 7'h00;
    tick(4);
    note(1, OFS_A);
    ADV_HOLDOVER_EN <= 1'b0;
    REF_VALID <= 7'h04;
    tick(12);
    MANUAL_REF_SEL <= 3'h4;
    SEL_PIN <= 3'h2;
    SLAVE_REF_SEL <= 3'h5;
    SLAVE_PIN <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      REFERENCE_MODE_CODE <= md[i];
      REF_VALID <= vl[i];
      tick(12);
      note(2, {28'h0, md[i]});
      note(0, {22'h0, ex[i]});
    end
    for (int c = 5; c < 16; c++) begin
      REFERENCE_MODE_CODE <= 4'(c);
      tick(2);
      note(2, 32'h4);
    end
    for (int i = 0; i < 8; i++) begin
      r = (i < 2) ? BW_TABLE[5] - 32'(i) : ($urandom % 32'h08000000);
      BW_REQUEST <= r;
      e = 0;
      for (int j = 0; j < BW_N; j++) begin
        if (BW_TABLE[j] <= r) begin
          e = j;
        end
      end
      tick(3);
      note(3, 32'(e));
    end
    final_report();
  end
endmodule
`default_nettype wire
